// ### core/ccr_command_ctrl.sv
// The strobed register port was decided locally.
module ccr_command_ctrl
   import ccr_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output      logic [7:0]  regRdata,
   input  wire logic        txStart,
   input  wire logic        txComplete,
   input  wire logic        rxMsgStored,
   input  wire logic        canIrqPending,
   input  wire logic        lineDiffActive,
   input  wire logic        busLineAVsRef,
   input  wire logic        busLineBVsRef,
   input  wire logic        busFree,
   output      ccr_status_t status,
   output      logic [1:0]  rxSlotFull,
   output      logic        rxSlotCur,
   output      logic        rxBlocked,
   output      logic        sleeping,
   output      logic        wakeIrq,
   output      logic        wakeStyle,
   output      logic [1:0]  lineSwitch,
   output      ccr_route_t  route
);

   logic        wrCmd;
   logic        rdCmd;
   logic        doSend;
   logic        doAbort;
   logic        doRelease;
   logic        doClrOvr;
   logic        busActive;
   logic        rxStore;
   logic        storeOverrun;
   logic [1:0]  relFull;
   logic        relCur;
   logic        storeSlot;
   ccr_status_t next_status;
   logic [1:0]  next_rxSlotFull;
   logic        next_rxSlotCur;
   logic        next_wakeStyle;
   logic [1:0]  next_lineSwitch;
   ccr_route_t  next_route;
   logic [7:0]  next_regRdata;
   ccr_sleep_t  sleepState;
   ccr_sleep_t  next_sleepState;
   logic        sleepCmd;
   logic        next_sleepCmd;
   logic        next_sleeping;
   logic        next_wakeIrq;
   logic        next_rxBlocked;

   assign wrCmd = regWr && (regAddr == CCR_CMD_ADDR);
   assign rdCmd = regRd && (regAddr == CCR_CMD_ADDR);

   // command pulses live only in the write cycle
   assign doSend    = wrCmd && regWdata[CCR_BIT_SEND];
   assign doAbort   = wrCmd && regWdata[CCR_BIT_ABORT];
   assign doRelease = wrCmd && regWdata[CCR_BIT_REL];
   assign doClrOvr  = wrCmd && regWdata[CCR_BIT_CLROV];

   // wake detector source chosen by wake style
   assign busActive = wakeStyle ? (busLineAVsRef || busLineBVsRef) : lineDiffActive;

   // messages are dropped while reception is blocked
   assign rxStore = rxMsgStored && !rxBlocked;

   // release frees the presented slot, the other full one follows
   always_comb
   begin
      relFull = rxSlotFull;
      relCur  = rxSlotCur;
      if (doRelease)
      begin
         relFull[rxSlotCur] = 1'b0;
         if (rxSlotFull[~rxSlotCur])
         begin
            relCur = ~rxSlotCur;
         end
      end
   end

   // store target and overrun when both slots stay full
   assign storeSlot    = relFull[relCur] ? ~relCur : relCur;
   assign storeOverrun = rxStore && (&relFull);

   // next values of the command, transmit and receive state
   always_comb
   begin
      next_status     = status;
      next_rxSlotFull = relFull;
      next_rxSlotCur  = relCur;
      next_wakeStyle  = wakeStyle;
      next_lineSwitch = lineSwitch;
      next_route      = route;
      next_regRdata   = CCR_RD_RESET;
      // engine takes the pending request
      if (txStart && status.sendPending)
      begin
         next_status.sendPending = 1'b0;
         next_status.txActive    = 1'b1;
      end
      if (txComplete && status.txActive)
      begin
         next_status.txActive     = 1'b0;
         next_status.sendDoneFlag = 1'b1;
      end
      // abort only reaches a request not yet started
      if (doAbort && status.sendPending && !txStart)
      begin
         next_status.sendPending = 1'b0;
      end
      // only a one sets the request
      if (doSend)
      begin
         next_status.sendPending = 1'b1;
         if (!(txComplete && status.txActive))
         begin
            next_status.sendDoneFlag = 1'b0;
         end
      end
      next_status.txbufFreeFlag = !next_status.sendPending && !next_status.txActive;
      // release clears, a stored message sets again
      if (doRelease)
      begin
         next_status.rxBufFull = 1'b0;
      end
      if (rxStore && !storeOverrun)
      begin
         next_rxSlotFull[storeSlot] = 1'b1;
         next_status.rxBufFull      = 1'b1;
      end
      // overrun-clear, a new overrun in the same cycle wins
      if (doClrOvr)
      begin
         next_status.overrun = 1'b0;
      end
      if (storeOverrun)
      begin
         next_status.overrun = 1'b1;
      end
      if (wrCmd)
      begin
         next_wakeStyle = regWdata[CCR_BIT_WAKE];
         if (regWdata[CCR_BIT_SWA] || regWdata[CCR_BIT_SWB])
         begin
            next_lineSwitch = {regWdata[CCR_BIT_SWA], regWdata[CCR_BIT_SWB]};
         end
      end
      case (next_lineSwitch)
         2'h3: next_route = '{aFromLine: 1'b1, aFromRef: 1'b0, bFromLine: 1'b1, bFromRef: 1'b0};
         2'h2: next_route = '{aFromLine: 1'b1, aFromRef: 1'b0, bFromLine: 1'b0, bFromRef: 1'b1};
         2'h1: next_route = '{aFromLine: 1'b0, aFromRef: 1'b1, bFromLine: 1'b1, bFromRef: 1'b0};
         default: next_route = route;
      endcase
      // read image, low bits read as ones
      if (rdCmd)
      begin
         // switch bits read the live switch state
         next_regRdata = {lineSwitch, wakeStyle, sleeping, CCR_LOW_READ};
      end
   end

   // registers of the command, transmit and receive state
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         status     <= '{txbufFreeFlag: 1'b1, default: 1'b0};
         rxSlotFull <= 2'h0;
         rxSlotCur  <= 1'b0;
         wakeStyle  <= CCR_WAKE_RST;
         lineSwitch <= CCR_SW_RESET;
         route      <= '{aFromLine: 1'b1, aFromRef: 1'b0, bFromLine: 1'b1, bFromRef: 1'b0};
         regRdata   <= CCR_RD_RESET;
      end
      else if (clkEn)
      begin
         status     <= next_status;
         rxSlotFull <= next_rxSlotFull;
         rxSlotCur  <= next_rxSlotCur;
         wakeStyle  <= next_wakeStyle;
         lineSwitch <= next_lineSwitch;
         route      <= next_route;
         regRdata   <= next_regRdata;
      end
   end

   // next values of the sleep controller
   always_comb
   begin
      next_sleepState = sleepState;
      next_sleepCmd   = wrCmd ? regWdata[CCR_BIT_SLEEP] : sleepCmd;
      next_wakeIrq    = 1'b0;
      next_rxBlocked  = rxBlocked && !busFree;
      case (sleepState)
         AWAKE:
         begin
            // enter only when quiet and no interrupt pending
            if (sleepCmd && !canIrqPending && !busActive)
            begin
               next_sleepState = ASLEEP;
            end
         end
         ASLEEP:
         begin
            // wake by software or bus, interrupt each time
            if (wrCmd && !regWdata[CCR_BIT_SLEEP])
            begin
               next_sleepState = AWAKE;
               next_wakeIrq    = 1'b1;
            end
            else if (busActive)
            begin
               next_sleepState = AWAKE;
               next_wakeIrq    = 1'b1;
               next_sleepCmd   = 1'b0;
               next_rxBlocked  = 1'b1;
            end
         end
         default: next_sleepState = AWAKE;
      endcase
      // sleep read-back is the real state
      next_sleeping = (next_sleepState == ASLEEP);
   end

   // registers of the sleep controller
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sleepState <= AWAKE;
         sleepCmd   <= 1'b0;
         sleeping   <= 1'b0;
         wakeIrq    <= 1'b0;
         rxBlocked  <= 1'b0;
      end
      else if (clkEn)
      begin
         sleepState <= next_sleepState;
         sleepCmd   <= next_sleepCmd;
         sleeping   <= next_sleeping;
         wakeIrq    <= next_wakeIrq;
         rxBlocked  <= next_rxBlocked;
      end
   end

   // checks on the command behaviour
   chk_low_bits_read: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && rdCmd |=> regRdata[3:0] == 4'hF)
      else $error("low command bits did not read as ones");
   chk_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && regRd && regAddr != 8'h01 |=> regRdata == 8'h00)
      else $error("unmapped read returned nonzero data");
   chk_sleep_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && rdCmd |=> regRdata[4] == $past(sleeping))
      else $error("sleep bit read does not match sleep state");
   chk_overrun_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && doClrOvr && !storeOverrun |=> !status.overrun)
      else $error("overrun flag not cleared");
   chk_done_cleared: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && doSend && !txComplete |=> !status.sendDoneFlag && status.sendPending)
      else $error("send request did not clear send-done");
   chk_abort_pending: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && doAbort && !doSend && !txStart && status.sendPending |=> !status.sendPending)
      else $error("abort did not cancel pending request");
   chk_abort_running: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && doAbort && status.txActive && !txComplete |=> status.txActive)
      else $error("abort stopped a running transmission");
   chk_wake_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
      $fell(sleeping) |-> wakeIrq)
      else $error("wake-up without wake interrupt");
   chk_sleep_entry: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && !sleeping && sleepCmd && !canIrqPending && !busActive |=> sleeping)
      else $error("sleep not entered when allowed");
   chk_rx_blocked: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && rxBlocked && !doRelease |=> $stable(rxSlotFull))
      else $error("message stored while reception blocked");
   chk_release_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && doRelease && !rxStore |=> !status.rxBufFull)
      else $error("release did not clear buffer-full flag");
   chk_switch_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      clkEn && wrCmd && regWdata[7:6] == 2'h0 |=> $stable(lineSwitch) && $stable(route))
      else $error("switch code 00 changed routing");

endmodule : ccr_command_ctrl

// ### core/ccr_pkg.sv
package ccr_pkg;
   // register map
   localparam logic [7:0] CCR_CMD_ADDR  = 8'h01;
   localparam int         CCR_BIT_SEND  = 0;
   localparam int         CCR_BIT_ABORT = 1;
   localparam int         CCR_BIT_REL   = 2;
   localparam int         CCR_BIT_CLROV = 3;
   localparam int         CCR_BIT_SLEEP = 4;
   localparam int         CCR_BIT_WAKE  = 5;
   localparam int         CCR_BIT_SWB   = 6;
   localparam int         CCR_BIT_SWA   = 7;
   // read-back of the command pulse bits
   localparam logic [3:0] CCR_LOW_READ  = 4'hF;
   // values after reset
   localparam logic [1:0] CCR_SW_RESET  = 2'h3;
   localparam logic       CCR_WAKE_RST  = 1'h0;
   localparam logic [7:0] CCR_RD_RESET  = 8'h00;

   // sleep controller states
   typedef enum logic {
      AWAKE,
      ASLEEP
   } ccr_sleep_t;

   // transmit and receive status seen by the rest of the controller
   typedef struct packed {
      logic sendPending;
      logic txActive;
      logic txbufFreeFlag;
      logic sendDoneFlag;
      logic rxBufFull;
      logic overrun;
   } ccr_status_t;

   // comparator input routing
   typedef struct packed {
      logic aFromLine;
      logic aFromRef;
      logic bFromLine;
      logic bFromRef;
   } ccr_route_t;
endpackage : ccr_pkg

// ### verification/ccr_command_ctrl_tb_top.sv
module ccr_command_ctrl_tb_top;
   import ccr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [7:0] wr;
      logic [7:0] rd;
      logic [3:0] rt;
   } ccr_row_t;

   logic        core_clk    = 1'b0;
   logic        rst_b       = 1'b0;
   logic        clkEn       = 1'b1;
   logic [5:0]  ev          = 6'h00;
   logic        canIrqPending = 1'b0;
   logic        lineA         = 1'b0;
   logic [7:0]  regAddr, regWdata, regRdata, rdVal;
   logic        regWr, regRd, rxSlotCur, rxBlocked, sleeping, wakeIrq, wakeStyle;
   logic [1:0]  rxSlotFull, lineSwitch;
   ccr_status_t status;
   ccr_route_t  route;
   int          num_errors      = 0;
   int          samples_checked = 0;
   // switch codes and wake style with expected image and routing
   ccr_row_t    rows[5] = '{'{8'hC0, 8'hCF, 4'hA}, '{8'h80, 8'h8F, 4'h9},
                            '{8'h40, 8'h4F, 4'h6}, '{8'h00, 8'h4F, 4'h6},
                            '{8'hE0, 8'hEF, 4'hA}};

   // 50 MHz clock
   always #10 core_clk = ~core_clk;

   ccr_cpu_model cpu (.core_clk(core_clk), .regRdata(regRdata), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd));

   ccr_command_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .txStart(ev[0]), .txComplete(ev[1]), .rxMsgStored(ev[2]),
      .canIrqPending(canIrqPending), .lineDiffActive(ev[3]), .busLineAVsRef(lineA),
      .busLineBVsRef(ev[4]), .busFree(ev[5]), .status(status), .rxSlotFull(rxSlotFull),
      .rxSlotCur(rxSlotCur), .rxBlocked(rxBlocked), .sleeping(sleeping),
      .wakeIrq(wakeIrq), .wakeStyle(wakeStyle), .lineSwitch(lineSwitch), .route(route));

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic w(input logic [7:0] d);
      cpu.wr(CCR_CMD_ADDR, d);
      @(negedge core_clk);
   endtask : w

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      cpu.rd(a, rdVal);
      chk("readData", rdVal, exp);
   endtask : rdchk

   // one-cycle event pulse, returns where outputs have settled
   task automatic pulse(input logic [5:0] v);
      @(posedge core_clk);
      ev <= v;
      @(posedge core_clk);
      ev <= 6'h00;
      @(negedge core_clk);
   endtask : pulse

   task automatic waitWake();
      for (int k = 0; k < 3 && wakeIrq !== 1'b1; k++) @(negedge core_clk);
      chk("wakeIrq", wakeIrq, 1'b1);
      chk("sleeping", sleeping, 1'b0);
   endtask : waitWake

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   // hang guard
   initial
   begin
      repeat (3000) @(posedge core_clk);
      num_errors++;
      $display("Error watchdog expected done seen hang");
      report_and_stop();
   end

   // main sequence
   initial
   begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      foreach (rows[i])
      begin
         w(rows[i].wr);
         chk("route", route, rows[i].rt);
         chk("lineSwitch", lineSwitch, rows[i].rd[7:6]);
         chk("wakeStyle", wakeStyle, rows[i].rd[5]);
         rdchk(CCR_CMD_ADDR, rows[i].rd);
      end
      $display("switch table done");
      w(8'h01);
      chk("status", status, 8'h20);
      w(8'h00);
      chk("status", status, 8'h20);
      pulse(6'h01);
      w(8'h02);
      chk("status", status, 8'h10);
      pulse(6'h02);
      chk("status", status, 8'h0C);
      w(8'h01);
      chk("status", status, 8'h20);
      w(8'h02);
      chk("status", status, 8'h08);
      $display("transmit done");
      pulse(6'h04);
      pulse(6'h04);
      chk("rxSlotFull", rxSlotFull, 2'h3);
      pulse(6'h04);
      w(8'h00);
      chk("status", status, 8'h0B);
      cpu.rel(1'b0);
      @(negedge core_clk);
      chk("rxSlotCur", rxSlotCur, 1'b1);
      chk("status", status, 8'h09);
      cpu.rel(1'b1);
      @(negedge core_clk);
      chk("status", status, 8'h08);
      pulse(6'h04);
      chk("status", status, 8'h0A);
      cpu.rel(1'b0);
      $display("receive done");
      @(posedge core_clk);
      canIrqPending <= 1'b1;
      cpu.sleepWith(2'h3, 1'b1);
      repeat (3) @(negedge core_clk);
      chk("sleeping", sleeping, 1'b0);
      @(posedge core_clk);
      canIrqPending <= 1'b0;
      repeat (3) @(negedge core_clk);
      rdchk(CCR_CMD_ADDR, 8'hFF);
      pulse(6'h08);
      chk("sleeping", sleeping, 1'b1);
      pulse(6'h10);
      waitWake();
      chk("rxBlocked", rxBlocked, 1'b1);
      pulse(6'h04);
      chk("rxSlotFull", rxSlotFull, 2'h0);
      pulse(6'h20);
      chk("rxBlocked", rxBlocked, 1'b0);
      rdchk(CCR_CMD_ADDR, 8'hEF);
      // single-ended wake through line A
      cpu.sleepWith(2'h3, 1'b1);
      repeat (3) @(negedge core_clk);
      @(posedge core_clk);
      lineA <= 1'b1;
      @(posedge core_clk);
      lineA <= 1'b0;
      @(negedge core_clk);
      waitWake();
      pulse(6'h20);
      chk("rxBlocked", rxBlocked, 1'b0);
      // differential wake ignores single line B
      cpu.sleepWith(2'h3, 1'b0);
      repeat (3) @(negedge core_clk);
      pulse(6'h10);
      chk("sleeping", sleeping, 1'b1);
      pulse(6'h08);
      waitWake();
      chk("rxBlocked", rxBlocked, 1'b1);
      pulse(6'h20);
      // software wake leaves reception open
      cpu.sleepWith(2'h3, 1'b0);
      repeat (3) @(negedge core_clk);
      chk("sleeping", sleeping, 1'b1);
      w(8'hC0);
      waitWake();
      chk("rxBlocked", rxBlocked, 1'b0);
      $display("sleep done");
      @(posedge core_clk);
      rst_b <= 1'b0;
      @(negedge core_clk);
      chk("status", status, 8'h08);
      @(posedge core_clk);
      rst_b <= 1'b1;
      cpu.wr(8'h02, 8'h01);
      @(negedge core_clk);
      chk("status", status, 8'h08);
      chk("route", route, 4'hA);
      rdchk(CCR_CMD_ADDR, 8'hCF);
      rdchk(8'h02, 8'h00);
      $display("reset done");
      // a write while the clock enable is low is not taken
      @(posedge core_clk);
      clkEn <= 1'b0;
      cpu.wr(CCR_CMD_ADDR, 8'h01);
      @(posedge core_clk);
      clkEn <= 1'b1;
      @(negedge core_clk);
      chk("status", status, 8'h08);
      $display("clock enable done");
      report_and_stop();
   end
endmodule : ccr_command_ctrl_tb_top

// ### verification/ccr_cpu_model.sv
// cpu side of the command register bus
module ccr_cpu_model
   import ccr_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic [7:0] regRdata,
   output      logic [7:0] regAddr,
   output      logic [7:0] regWdata,
   output      logic       regWr,
   output      logic       regRd
);
   timeunit 1ns;
   timeprecision 1ns;

   // bus idle from time zero
   initial
   begin
      regAddr  = 8'h00;
      regWdata = 8'h00;
      regWr    = 1'b0;
      regRd    = 1'b0;
   end

   // one-cycle write, strobe dropped after the taking edge
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge core_clk);
      regWr    <= 1'b1;
      regAddr  <= addr;
      regWdata <= data;
      @(posedge core_clk);
      regWr    <= 1'b0;
   endtask : wr

   // one-cycle read, data taken in the following cycle
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= addr;
      @(posedge core_clk);
      regRd   <= 1'b0;
      @(negedge core_clk);
      data = regRdata;
   endtask : rd

   // spaced release, overrun cleared with it when clr is set
   task automatic rel(input logic clr);
      wr(CCR_CMD_ADDR, {4'h0, clr, 3'h4});
      repeat (3) @(posedge core_clk);
   endtask : rel

   // wake style written with the sleep bit
   task automatic sleepWith(input logic [1:0] sw, input logic style);
      wr(CCR_CMD_ADDR, {sw, style, 1'b1, 4'h0});
   endtask : sleepWith
endmodule : ccr_cpu_model
